// ===== rtl/reset_pulse_and_mode_select.sv
// Purpose: Reset pin pulse, reset cause record, boot mode capture and background line bit engine
// Assumes: All inputs synchronous to CLK; ARST_N is the power-on reset
// Notes: Debug clock equals the bus clock, so a bit lasts BIT_CYCLES clocks
`include "reset_seq_regs.svh"
`timescale 1ns/1ps
`default_nettype none

// Function
// - Any reset drives reset pin low 34 cycles; power-on holds it low while ARST_N is low and then 34 cycles more
// - Record which source caused the reset
// - Debug pin is mode input in reset
// - Debug pin pull-up always enabled
// - High at release selects normal mode
// - Low at release selects background mode
// - Each background bit lasts 16 debug clocks
// - Pseudo open-drain with speedup pulse on release
// - Reset forces ports to input, no pull-ups
// - Load protection and option bytes at reset
module reset_pulse_and_mode_select #(
  parameter int PULSE_CYCLES = `RST_PULSE_CYCLES,
  parameter int INT_SRC_N = 4,
  parameter int BIT_CYCLES = `BDC_BIT_CYCLES,
  parameter int LOW_ONE = `BDC_LOW_ONE,
  parameter int LOW_ZERO = `BDC_LOW_ZERO,
  parameter int SAMPLE_AT = `BDC_SAMPLE_AT
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic [INT_SRC_N-1:0] INT_RST_REQ,
  input wire logic RESET_PIN_IN,
  output logic RESET_PIN_OUT,
  output logic RESET_PIN_OE,
  output logic SYS_RST_N,
  output reset_seq_pkg::reset_cause_type RESET_CAUSE,
  output logic [INT_SRC_N-1:0] INT_CAUSE,
  input wire logic DBG_PIN_IN,
  output logic DBG_PIN_OUT,
  output logic DBG_PIN_OE,
  output logic DBG_PULLUP_EN,
  output logic BOOT_BACKGROUND,
  output logic PORT_FORCE_INPUT,
  output logic [15:0] NV_ADDR,
  output logic NV_RD,
  input wire logic [7:0] NV_DATA,
  output reset_seq_pkg::nv_bytes_type NV_BYTES,
  input wire logic TX_VALID,
  input wire logic TX_BIT,
  output logic TX_READY,
  output logic TX_DONE,
  output logic RX_VALID,
  output logic RX_BIT
);
  localparam int PW = $clog2(PULSE_CYCLES + 1);
  localparam int BW = $clog2(BIT_CYCLES + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Parameter checks: byte load needs a few pulse cycles, low times and sample must fit in a bit
  initial begin
    if (PULSE_CYCLES < 4 || INT_SRC_N < 1 || LOW_ONE < 1 || LOW_ZERO <= LOW_ONE
        || LOW_ZERO + 1 >= BIT_CYCLES || SAMPLE_AT <= LOW_ONE || SAMPLE_AT >= BIT_CYCLES - 1) begin
      $error("Parameters outside what the sequencer supports");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Functions
  // Pin drive for a transmit bit at a given count: {oe, out}
  function automatic logic [1:0] tx_drive(input logic [BW-1:0] cnt, input logic bit_val);
    logic [BW-1:0] low_len;
    low_len = bit_val ? BW'(LOW_ONE) : BW'(LOW_ZERO);
    if (cnt < low_len) begin
      tx_drive = 2'b10;
    end else if (cnt == low_len) begin
      tx_drive = 2'b11;
    end else begin
      tx_drive = 2'b00;
    end
  endfunction : tx_drive

  ////////////////////////////////////////////////////////////////////////////
  // Reset sequencing
  reset_seq_pkg::rst_state_type rst_state_q;
  logic [PW-1:0] pulse_cnt_q;
  reset_seq_pkg::reset_cause_type cause_q;
  logic [INT_SRC_N-1:0] int_cause_q;
  logic boot_bg_q, new_reset, release_now;

  // A new reset in run: any internal request or the pin pulled low from outside
  assign new_reset = (rst_state_q == reset_seq_pkg::RST_RUN) && ((|INT_RST_REQ) || !RESET_PIN_IN);
  // Leave reset once the pin reads high, unless an internal request restarts the pulse
  assign release_now = (rst_state_q == reset_seq_pkg::RST_RELEASE) && RESET_PIN_IN && !(|INT_RST_REQ);

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_state_q <= reset_seq_pkg::RST_PULSE;
      pulse_cnt_q <= '0;
    end else begin
      case (rst_state_q)
        reset_seq_pkg::RST_PULSE: begin
          if (pulse_cnt_q == PW'(PULSE_CYCLES - 1)) begin
            rst_state_q <= reset_seq_pkg::RST_RELEASE;
            pulse_cnt_q <= '0;
          end else begin
            pulse_cnt_q <= pulse_cnt_q + PW'(1);
          end
        end
        reset_seq_pkg::RST_RELEASE: begin
          if (|INT_RST_REQ) begin
            rst_state_q <= reset_seq_pkg::RST_PULSE;
          end else if (RESET_PIN_IN) begin
            rst_state_q <= reset_seq_pkg::RST_RUN;
          end
        end
        reset_seq_pkg::RST_RUN: begin
          if (new_reset) begin
            rst_state_q <= reset_seq_pkg::RST_PULSE;
            pulse_cnt_q <= '0;
          end
        end
        default: begin
          rst_state_q <= reset_seq_pkg::RST_PULSE;
          pulse_cnt_q <= '0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cause_q <= '{por: 1'b1, ext_pin: 1'b0, internal: 1'b0};
      int_cause_q <= '0;
    end else if (new_reset || (rst_state_q == reset_seq_pkg::RST_RELEASE && (|INT_RST_REQ))) begin
      cause_q.por <= 1'b0;
      cause_q.ext_pin <= !(|INT_RST_REQ);
      cause_q.internal <= |INT_RST_REQ;
      int_cause_q <= INT_RST_REQ;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      boot_bg_q <= 1'b0;
    end else if (release_now) begin
      boot_bg_q <= !DBG_PIN_IN;
    end
  end

  // Reset pin is open drain: driven only low
  assign RESET_PIN_OUT = 1'b0;
  assign RESET_PIN_OE = (rst_state_q == reset_seq_pkg::RST_PULSE);

  assign SYS_RST_N = (rst_state_q == reset_seq_pkg::RST_RUN);
  assign RESET_CAUSE = cause_q;
  assign INT_CAUSE = int_cause_q;
  assign BOOT_BACKGROUND = boot_bg_q;

  assign PORT_FORCE_INPUT = (rst_state_q != reset_seq_pkg::RST_RUN);

  assign DBG_PULLUP_EN = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Nonvolatile byte load during the pulse
  reset_seq_pkg::nv_bytes_type nv_q;
  logic [15:0] nv_addr_q;
  logic nv_rd_q;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      nv_addr_q <= 16'h0000;
      nv_rd_q <= 1'b0;
      nv_q <= '{prot: `NV_BYTE_RESET, opt: `NV_BYTE_RESET};
    end else begin
      nv_rd_q <= 1'b0;
      if (rst_state_q == reset_seq_pkg::RST_PULSE) begin
        if (pulse_cnt_q == PW'(0)) begin
          nv_addr_q <= 16'(`NV_BASE_ADDR + `NV_PROT_OFFSET);
          nv_rd_q <= 1'b1;
        end else if (pulse_cnt_q == PW'(1)) begin
          nv_q.prot <= NV_DATA;
          nv_addr_q <= 16'(`NV_BASE_ADDR + `NV_OPT_OFFSET);
          nv_rd_q <= 1'b1;
        end else if (pulse_cnt_q == PW'(2)) begin
          nv_q.opt <= NV_DATA;
        end
      end
    end
  end

  assign NV_ADDR = nv_addr_q;
  assign NV_RD = nv_rd_q;
  assign NV_BYTES = nv_q;

  ////////////////////////////////////////////////////////////////////////////
  // Background line bit engine
  reset_seq_pkg::bdc_state_type bdc_state_q;
  logic [BW-1:0] bit_cnt_q;
  logic tx_bit_q, pin_prev_q, dbg_oe_q, dbg_out_q, rx_valid_q, rx_bit_q, tx_done_q, run;
  logic [1:0] drv_next;

  assign run = (rst_state_q == reset_seq_pkg::RST_RUN);
  assign TX_READY = run && (bdc_state_q == reset_seq_pkg::BDC_IDLE);
  assign drv_next = tx_drive(bit_cnt_q + BW'(1), tx_bit_q);

  // Previous line level for falling edge detection
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pin_prev_q <= 1'b1;
    end else begin
      pin_prev_q <= DBG_PIN_IN;
    end
  end

  // Engine runs only out of reset
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      bdc_state_q <= reset_seq_pkg::BDC_IDLE;
      bit_cnt_q <= '0;
      tx_bit_q <= 1'b0;
      rx_valid_q <= 1'b0;
      rx_bit_q <= 1'b0;
      tx_done_q <= 1'b0;
    end else begin
      rx_valid_q <= 1'b0;
      tx_done_q <= 1'b0;
      if (!run) begin
        bdc_state_q <= reset_seq_pkg::BDC_IDLE;
        bit_cnt_q <= '0;
      end else begin
        case (bdc_state_q)
          reset_seq_pkg::BDC_IDLE: begin
            bit_cnt_q <= '0;
            if (TX_VALID) begin
              bdc_state_q <= reset_seq_pkg::BDC_TX;
              tx_bit_q <= TX_BIT;
            end else if (pin_prev_q && !DBG_PIN_IN) begin
              bdc_state_q <= reset_seq_pkg::BDC_RX;
              bit_cnt_q <= BW'(1);
            end
          end
          reset_seq_pkg::BDC_RX: begin
            bit_cnt_q <= bit_cnt_q + BW'(1);
            if (bit_cnt_q == BW'(SAMPLE_AT)) begin
              rx_bit_q <= DBG_PIN_IN;
            end
            if (bit_cnt_q == BW'(BIT_CYCLES - 1)) begin
              rx_valid_q <= 1'b1;
              bdc_state_q <= reset_seq_pkg::BDC_IDLE;
            end
          end
          reset_seq_pkg::BDC_TX: begin
            bit_cnt_q <= bit_cnt_q + BW'(1);
            if (bit_cnt_q == BW'(BIT_CYCLES - 1)) begin
              tx_done_q <= 1'b1;
              bdc_state_q <= reset_seq_pkg::BDC_IDLE;
            end
          end
          default: begin
            bdc_state_q <= reset_seq_pkg::BDC_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      dbg_oe_q <= 1'b0;
      dbg_out_q <= 1'b0;
    end else if (TX_READY && TX_VALID) begin
      dbg_oe_q <= 1'b1;
      dbg_out_q <= 1'b0;
    end else if (run && bdc_state_q == reset_seq_pkg::BDC_TX && bit_cnt_q != BW'(BIT_CYCLES - 1)) begin
      dbg_oe_q <= drv_next[1];
      dbg_out_q <= drv_next[0];
    end else begin
      dbg_oe_q <= 1'b0;
      dbg_out_q <= 1'b0;
    end
  end

  assign DBG_PIN_OE = dbg_oe_q;
  assign DBG_PIN_OUT = dbg_out_q;
  assign RX_VALID = rx_valid_q;
  assign RX_BIT = rx_bit_q;
  assign TX_DONE = tx_done_q;

endmodule : reset_pulse_and_mode_select

`default_nettype wire

// ===== rtl/reset_seq_regs.svh
// Purpose: Constants for the reset pulse, nonvolatile load and background bit timing
// Assumes: Debug clock runs at the bus clock rate (20 MHz)
// Notes: Counts are in bus clock cycles
`ifndef RESET_SEQ_REGS_SVH
`define RESET_SEQ_REGS_SVH

// Reset pin low time in bus cycles
`define RST_PULSE_CYCLES 34
// Nonvolatile register area base and byte offsets
`define NV_BASE_ADDR 16'hFFB0
`define NV_PROT_OFFSET 16'h000D
`define NV_OPT_OFFSET 16'h000F
// Background line bit timing in debug clock cycles
`define BDC_BIT_CYCLES 16
`define BDC_LOW_ONE 4
`define BDC_LOW_ZERO 13
`define BDC_SAMPLE_AT 10
// Reset values of working bytes
`define NV_BYTE_RESET 8'hFF

`endif

// ===== rtl/reset_seq_pkg.sv
// Purpose: Types shared by the reset sequencer
// Assumes: Nothing beyond the constants header
// Notes: Structs carry grouped outputs
package reset_seq_pkg;

  // Sequencer phases
  typedef enum logic [1:0] {
    RST_PULSE,
    RST_RELEASE,
    RST_RUN
  } rst_state_type;

  // Background line engine phases
  typedef enum logic [1:0] {
    BDC_IDLE,
    BDC_RX,
    BDC_TX
  } bdc_state_type;

  // Recorded reset source class
  typedef struct packed {
    logic por;
    logic ext_pin;
    logic internal;
  } reset_cause_type;

  // Working copies of the nonvolatile bytes
  typedef struct packed {
    logic [7:0] prot;
    logic [7:0] opt;
  } nv_bytes_type;

endpackage : reset_seq_pkg

// ===== verification/reset_pulse_and_mode_select_asserts.sv
// Purpose: Port checks for the reset sequencer
// Assumes: One clock domain
// Notes: Bound to the top module
`include "reset_seq_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module rpms_checker #(
  parameter int INT_SRC_N = 4
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic [INT_SRC_N-1:0] INT_RST_REQ,
  input wire logic RESET_PIN_IN,
  input wire logic RESET_PIN_OUT,
  input wire logic RESET_PIN_OE,
  input wire logic SYS_RST_N,
  input wire reset_seq_pkg::reset_cause_type RESET_CAUSE,
  input wire logic [INT_SRC_N-1:0] INT_CAUSE,
  input wire logic DBG_PIN_IN,
  input wire logic DBG_PIN_OUT,
  input wire logic DBG_PIN_OE,
  input wire logic DBG_PULLUP_EN,
  input wire logic BOOT_BACKGROUND,
  input wire logic PORT_FORCE_INPUT,
  input wire logic [15:0] NV_ADDR,
  input wire logic NV_RD,
  input wire logic TX_VALID,
  input wire logic TX_BIT,
  input wire logic TX_READY,
  input wire logic TX_DONE
);
  logic [5:0] oe_cnt_q;
  logic tx_go;
  ////////////////////
  // Cycles the reset pin has been held low
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) oe_cnt_q <= 6'h0;
    else oe_cnt_q <= RESET_PIN_OE ? oe_cnt_q + 6'h1 : 6'h0;
  end
  // Accepted transmit request
  assign tx_go = TX_READY && TX_VALID;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  a_pulse_len: assert property ($fell(RESET_PIN_OE) && !RESET_CAUSE.por |-> oe_cnt_q == 6'h22)
    else $error("pulse length");
  a_int_start: assert property (SYS_RST_N && |INT_RST_REQ |=> RESET_PIN_OE && !SYS_RST_N
    && RESET_CAUSE == 3'h1 && INT_CAUSE == $past(INT_RST_REQ)) else $error("internal reset");
  a_pin_start: assert property (SYS_RST_N && !RESET_PIN_IN && !(|INT_RST_REQ) |=> RESET_PIN_OE
    && RESET_CAUSE == 3'h2 && INT_CAUSE == '0) else $error("pin reset");
  a_boot_mode: assert property ($rose(SYS_RST_N) |-> BOOT_BACKGROUND == !$past(DBG_PIN_IN))
    else $error("boot mode");
  a_mode_hold: assert property (SYS_RST_N && $past(SYS_RST_N) |-> $stable(BOOT_BACKGROUND))
    else $error("mode changed");
  a_pins_idle: assert property (DBG_PULLUP_EN && !RESET_PIN_OUT && PORT_FORCE_INPUT == !SYS_RST_N)
    else $error("pin defaults");
  a_tx_one: assert property (tx_go && TX_BIT |=> (DBG_PIN_OE && !DBG_PIN_OUT)[*4]
    ##1 (DBG_PIN_OE && DBG_PIN_OUT) ##1 !DBG_PIN_OE) else $error("bit one shape");
  a_tx_zero: assert property (tx_go && !TX_BIT |-> ##13 (DBG_PIN_OE && !DBG_PIN_OUT)
    ##1 (DBG_PIN_OE && DBG_PIN_OUT) ##1 !DBG_PIN_OE) else $error("bit zero shape");
  a_tx_done: assert property (tx_go |-> ##17 TX_DONE ##1 !TX_DONE)
    else $error("bit done");
  a_nv_fetch: assert property ($rose(RESET_PIN_OE) |=> (NV_RD && NV_ADDR == 16'(`NV_BASE_ADDR + `NV_PROT_OFFSET))
    ##1 (NV_RD && NV_ADDR == 16'(`NV_BASE_ADDR + `NV_OPT_OFFSET)) ##1 !NV_RD) else $error("byte fetch");
  // Main scenarios
  cover property ($rose(SYS_RST_N) && BOOT_BACKGROUND);
  cover property ($fell(RESET_PIN_OE) && RESET_CAUSE.ext_pin);
  cover property (TX_DONE);
endmodule : rpms_checker
bind reset_pulse_and_mode_select rpms_checker #(.INT_SRC_N(INT_SRC_N)) rpms_checker_i (
  .CLK, .ARST_N, .INT_RST_REQ, .RESET_PIN_IN, .RESET_PIN_OUT, .RESET_PIN_OE, .SYS_RST_N, .RESET_CAUSE,
  .INT_CAUSE, .DBG_PIN_IN, .DBG_PIN_OUT, .DBG_PIN_OE, .DBG_PULLUP_EN, .BOOT_BACKGROUND, .PORT_FORCE_INPUT,
  .NV_ADDR, .NV_RD,
  .TX_VALID, .TX_BIT, .TX_READY, .TX_DONE
);
`default_nettype wire

// ===== verification/debug_host_model.sv
// Purpose: Debug host on the shared mode and background line
// Assumes: Called at the falling clock edge
// Notes: Pseudo open-drain, low wins on the wire
`include "reset_seq_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module debug_host_model (
  input wire logic clk,
  output logic drv_oe,
  output logic drv_out
);
  ////////////////////
  // hold low over release
  task automatic hold(input logic low);
    drv_out = 1'b0;
    drv_oe = low;
  endtask : hold
  task automatic send_bit(input logic b, input int gap);
    drv_oe = 1'b1;
    repeat (b ? `BDC_LOW_ONE : `BDC_LOW_ZERO) @(negedge clk);
    drv_out = 1'b1;
    @(negedge clk);
    drv_oe = 1'b0;
    drv_out = 1'b0;
    repeat (`BDC_BIT_CYCLES + 1 + gap - (b ? `BDC_LOW_ONE : `BDC_LOW_ZERO)) @(negedge clk);
  endtask : send_bit
endmodule : debug_host_model
`default_nettype wire

// ===== verification/reset_pulse_and_mode_select_test.sv
// Purpose: Random bench for the reset sequencer
// Assumes: Host model on the debug line
// Notes: Pin levels are resolved here
`include "reset_seq_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module reset_pulse_and_mode_select_test;
  logic clk, arst_n, ext_low, tx_valid, tx_bit, oe, rst_n, dbg_oe, dbg_out, boot;
  logic tx_ready, tx_done, rx_valid, rx_bit, host_oe, host_out, rx_exp;
  logic [3:0] int_req, int_cause;
  logic [7:0] nv_data, prot_v, opt_v;
  logic [15:0] nv_addr;
  reset_seq_pkg::reset_cause_type cause;
  reset_seq_pkg::nv_bytes_type nv_bytes;
  int fail_count, check_count, rx_n;
  integer seed = 32'hcb24_45fe;
  // Both pins have pull-ups, low wins
  wire rst_line = !(oe || ext_low);
  wire dbg_line = !((dbg_oe && !dbg_out) || (host_oe && !host_out));
  reset_pulse_and_mode_select reset_pulse_and_mode_select_i (
    .CLK(clk), .ARST_N(arst_n), .INT_RST_REQ(int_req), .RESET_PIN_IN(rst_line), .RESET_PIN_OUT(),
    .RESET_PIN_OE(oe), .SYS_RST_N(rst_n), .RESET_CAUSE(cause), .INT_CAUSE(int_cause),
    .DBG_PIN_IN(dbg_line), .DBG_PIN_OUT(dbg_out), .DBG_PIN_OE(dbg_oe), .DBG_PULLUP_EN(),
    .BOOT_BACKGROUND(boot), .PORT_FORCE_INPUT(), .NV_ADDR(nv_addr), .NV_RD(), .NV_DATA(nv_data),
    .NV_BYTES(nv_bytes), .TX_VALID(tx_valid), .TX_BIT(tx_bit), .TX_READY(tx_ready), .TX_DONE(tx_done),
    .RX_VALID(rx_valid), .RX_BIT(rx_bit));
  debug_host_model debug_host_model_i (.clk(clk), .drv_oe(host_oe), .drv_out(host_out));
  ////////////////////
  // Clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Nonvolatile area answers the current address at the falling edge
  always @(negedge clk) begin
    nv_data <= (nv_addr == (`NV_BASE_ADDR + `NV_PROT_OFFSET)) ? prot_v : opt_v;
  end
  // Received bits against what the host sent
  always @(negedge clk) begin
    if (rx_valid === 1'b1) begin
      rx_n++;
      chk(rx_bit, rx_exp);
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic results;
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results
  // Bounded wait for a high level
  task automatic wait_for(ref logic s);
    int k;
    k = 0;
    while (s !== 1'b1) begin
      @(negedge clk);
      k++;
      if (k > 100) begin
        fail_count++;
        results();
      end
    end
  endtask : wait_for
  function automatic logic [15:0] low_len(input logic b);
    return b ? 16'(`BDC_LOW_ONE) : 16'(`BDC_LOW_ZERO);
  endfunction : low_len
  // Kind 0 power-on, 1 internal, 2 pin; norm 1 leaves the mode line high
  task automatic do_reset(input int kind, input logic norm);
    int n;
    logic [3:0] req;
    req = 4'($random(seed));
    if (kind != 1) req = 4'h0;
    else if (req == 4'h0) req = 4'h8;
    prot_v = 8'($random(seed));
    opt_v = 8'($random(seed));
    debug_host_model_i.hold(!norm);
    if (kind == 0) arst_n = 1'b0;
    else if (kind == 1) int_req = req;
    else ext_low = 1'b1;
    repeat (kind == 0 ? 8 : 1) @(negedge clk);
    arst_n = 1'b1;
    int_req = 4'h0;
    ext_low = 1'b0;
    n = 0;
    repeat (40) begin
      if (oe === 1'b1) n++;
      @(negedge clk);
    end
    wait_for(rst_n);
    debug_host_model_i.hold(1'b0);
    @(negedge clk); // Let an edge pass before the next reset drives the line again
    if (kind != 0) chk(16'(n), `RST_PULSE_CYCLES);
    chk(cause, kind == 0 ? 3'h4 : kind == 1 ? 3'h1 : 3'h2);
    chk(int_cause, req);
    chk(boot, !norm);
    chk(nv_bytes, {prot_v, opt_v});
  endtask : do_reset
  // Main sequence
  initial begin
    int lows, dones;
    arst_n = 1'b0;
    int_req = 4'h0;
    ext_low = 1'b0;
    tx_valid = 1'b0;
    tx_bit = 1'b0;
    rx_exp = 1'b0;
    fail_count = 0;
    check_count = 0;
    #1;
    do_reset(0, 1'b0);
    for (int i = 1; i < 7; i++) begin
      do_reset(i % 3, 1'($random(seed)));
    end
    for (int i = 0; i < 8; i++) begin
      tx_bit = (i < 2) ? i[0] : 1'($random(seed));
      wait_for(tx_ready);
      tx_valid = 1'b1;
      @(negedge clk);
      tx_valid = 1'b0;
      lows = 0;
      dones = 0;
      repeat (`BDC_BIT_CYCLES + 1) begin // Done pulse follows the last bit edge
        if (dbg_line === 1'b0) lows++;
        if (tx_done === 1'b1) dones++;
        @(negedge clk);
      end
      chk(16'(lows), low_len(tx_bit));
      chk(16'(dones), 16'h0001);
    end
    for (int i = 0; i < 6; i++) begin
      rx_exp = 1'($random(seed));
      debug_host_model_i.send_bit(rx_exp, i % 3);
    end
    chk(16'(rx_n), 16'h0006);
    results();
  end
endmodule : reset_pulse_and_mode_select_test
`default_nettype wire
